// file: design/arcmd_params.svh
`ifndef ARCMD_PARAMS_SVH
`define ARCMD_PARAMS_SVH
`define ARCMD_CLK_HZ 50000000
`define ARCMD_TICK_US 1000
`define ARCMD_TICK_CYC ((`ARCMD_CLK_HZ / 1000000) * `ARCMD_TICK_US)
`define ARCMD_DROP_MS 100
`define ARCMD_DROP_TICKS (`ARCMD_DROP_MS * 1000 / `ARCMD_TICK_US)
`define ARCMD_DEAD_TICKS_RST 16'h01F4
`define ARCMD_CH_NUM 8
`define ARCMD_TRIP_NUM 5
`endif

// file: design/arcmd_pkg.sv
package arcmd_pkg;
	typedef enum logic [1:0]
	{
		ARCMD_INIT_NONE = 2'h0,
		ARCMD_INIT_MAIN = 2'h1,
		ARCMD_INIT_SEF = 2'h2,
		ARCMD_INIT_BLOCK = 2'h3
	} arcmd_init_e;
	typedef enum logic [1:0]
	{
		ARCMD_SEL_COMMAND = 2'h0,
		ARCMD_SEL_OPTO = 2'h1,
		ARCMD_SEL_USER = 2'h2,
		ARCMD_SEL_PULSE = 2'h3
	} arcmd_sel_e;
	typedef enum logic [2:0]
	{
		ARCMD_DT_IDLE = 3'h1,
		ARCMD_DT_PRIMED = 3'h2,
		ARCMD_DT_DONE = 3'h4
	} arcmd_dt_e;
endpackage : arcmd_pkg

// file: design/arcmd_tick.sv
`timescale 1ns/1ns
`include "arcmd_params.svh"
module arcmd_tick
	import arcmd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	output logic tick
);
	logic [15:0] cnt_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt_q == 16'(`ARCMD_TICK_CYC - 1))
		begin
			cnt_q <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : arcmd_tick

// file: design/arcmd_dropoff.sv
`timescale 1ns/1ns
`include "arcmd_params.svh"
module arcmd_dropoff
	import arcmd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic din,
	output logic dout
);
	// Input is already synchronised; output holds high for the drop-off time after din falls.
	logic [7:0] cnt_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 8'h00;
			dout <= 1'b0;
		end
		else if (din)
		begin
			cnt_q <= 8'(`ARCMD_DROP_TICKS);
			dout <= 1'b1;
		end
		else if (tick && cnt_q != 8'h00)
		begin
			cnt_q <= cnt_q - 8'h01;
			dout <= (cnt_q != 8'h01);
		end
	end
endmodule : arcmd_dropoff

// file: design/arcmd_top.sv
// Behaviour
// - Auto, remote-select and live-line inputs get a drop-off stretch.
// - In user or pulse-set selection, moving to remote position keeps previous mode until a remote command.
// - In command selection, auto-mode memory is restored from non-volatile storage after power return.
// - Each stage chooses main initiate, no action, block, or sensitive initiate.
// - A no-action stage trips but starts no reclose.
// - External trip and start initiate only when their choice is main.
// - Initiation is accepted from both protection trip and protection start.
// - Initiate needs auto, no live-line, shots free, no lockout, in service; a start also needs coordination.
// - Per-trip main and sensitive settings choose instantaneous blocking.
// - Penultimate lockout count with blocking setting blocks instantaneous protection.
// - Lockout, manual-close period or non-auto block instantaneous when selected.
// - Main and sensitive protection block outputs are provided.
// - Prime dead time on breaker trip, protection reset if required, permission high.
// - Dead time stays primed until protection re-operates or scheme resets.
// - Primed dead timer runs only while dead-time enable is high.
// - Immediate synchronised reclose permits closing once dead time has started.
// - Without immediate reclose conditions the dead timer keeps running while enabled.
// - An unmapped dead-time enable counts as permanently high.
// - Live-line input forces live-line mode over all other selection.
// - Pulse-set with remote-select high toggles mode on auto falling edge.
// - Dead-time-in-progress is high while reclose checks and enable are high.
`timescale 1ns/1ns
`include "arcmd_params.svh"
module arcmd_top
	import arcmd_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic AUTO_IN,
	input wire logic REMOTE_SEL_IN,
	input wire logic LIVE_LINE_IN,
	input wire logic [1:0] MODE_SELECT,
	input wire logic CMD_AUTO,
	input wire logic CMD_NON_AUTO,
	input wire logic NV_AUTO_MEM,
	input wire logic NV_VALID,
	input wire logic [15:0] STAGE_START,
	input wire logic [15:0] STAGE_TRIP,
	input wire logic [15:0] STAGE_CHOICE,
	input wire logic EXTERNAL_TRIP_INITIATE,
	input wire logic EXTERNAL_START_INITIATE,
	input wire logic [1:0] EXT_CHOICE,
	input wire logic SEQ_COORD_EN,
	input wire logic MAIN_SHOTS_REACHED,
	input wire logic SEF_SHOTS_REACHED,
	input wire logic CB_LOCKOUT,
	input wire logic IN_SERVICE,
	input wire logic [2:0] TRIP_NUMBER,
	input wire logic [4:0] PER_TRIP_MAIN_INST_BLOCK,
	input wire logic [4:0] PER_TRIP_SENSITIVE_INST_BLOCK,
	input wire logic PENULTIMATE_COUNT,
	input wire logic PENULTIMATE_COUNT_BLOCK_SETTING,
	input wire logic LOCKOUT_BLOCK_SETTING,
	input wire logic MANUAL_CLOSE_ACTIVE,
	input wire logic MANUAL_CLOSE_BLOCK_SETTING,
	input wire logic NON_AUTO_BLOCK_SETTING,
	input wire logic CB_OPEN,
	input wire logic START_ON_PROT_RESET,
	input wire logic DEAD_TIME_START_PERMISSION,
	input wire logic DEAD_TIME_ENABLE,
	input wire logic DEAD_TIME_ENABLE_MAPPED,
	input wire logic IMMEDIATE_SYNCHRONISED_RECLOSE,
	input wire logic BOTH_LIVE_IN_SYNC,
	input wire logic SCHEME_RESET,
	input wire logic [15:0] DEAD_TIME_TICKS,
	output logic AUTO_MODE,
	output logic LIVE_LINE_MODE,
	output logic NV_AUTO_MEM_OUT,
	output logic RECLOSE_INITIATE,
	output logic SENSITIVE_RECLOSE_INITIATE,
	output logic RECLOSE_BLOCKED,
	output logic TRIP_NO_RECLOSE,
	output logic MAIN_PROTECTION_BLOCK_OUT,
	output logic SENSITIVE_PROTECTION_BLOCK_OUT,
	output logic RECLOSE_CHECKS,
	output logic DEAD_TIME_IN_PROGRESS,
	output logic DEAD_TIME_COMPLETE,
	output logic CLOSE_PERMIT
);
	// Pins from the selector, breaker and other relays arrive asynchronously.
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic tick;
	logic auto_f;
	logic remote_f;
	logic live_f;
	logic auto_f_q;
	logic remote_f_q;
	logic auto_mem_q;
	logic nv_loaded_q;
	logic auto_eff;
	logic live_eff;
	logic any_prot_q;
	logic prot_op;
	logic cb_open_s;
	logic permit_s;
	logic dte_s;
	logic dt_run;
	logic [15:0] dt_cnt_q;
	logic main_trip;
	logic main_start;
	logic sef_trip;
	logic sef_start;
	logic block_req;
	logic noact_trip;
	logic gate_ok;
	logic inst_cond;
	logic [2:0] trip_idx;
	arcmd_dt_e dt_q;
	arcmd_sel_e sel;
	assign sel = arcmd_sel_e'(MODE_SELECT);
	assign pin_raw = {DEAD_TIME_ENABLE, DEAD_TIME_START_PERMISSION, CB_OPEN,
		LIVE_LINE_IN, REMOTE_SEL_IN, AUTO_IN};
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end
	assign cb_open_s = sync2_q[3];
	assign permit_s = sync2_q[4];
	assign dte_s = DEAD_TIME_ENABLE_MAPPED ? sync2_q[5] : 1'b1;
	arcmd_tick u_tick
	(
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.tick(tick)
	);
	// One drop-off stretcher per selector input.
	genvar gi;
	logic [2:0] filt;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_drop
			arcmd_dropoff u_drop
			(
				.clk(CORE_CLK),
				.arst_n(ARST_N),
				.tick(tick),
				.din(sync2_q[gi]),
				.dout(filt[gi])
			);
		end
	endgenerate
	assign auto_f = filt[0];
	assign remote_f = filt[1];
	assign live_f = filt[2];
	// Mode memory. The stored copy is loaded once after reset so that, in command selection, a brown-out
	// restores the mode rather than falling back to non-auto; opto, and user or pulse-set with remote low, load auto_f on the next clock.
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			auto_mem_q <= 1'b0;
			nv_loaded_q <= 1'b0;
			auto_f_q <= 1'b0;
			remote_f_q <= 1'b0;
		end
		else
		begin
			auto_f_q <= auto_f;
			remote_f_q <= remote_f;
			if (!nv_loaded_q)
			begin
				nv_loaded_q <= 1'b1;
				auto_mem_q <= NV_VALID ? NV_AUTO_MEM : 1'b0;
			end
			else if (sel == ARCMD_SEL_COMMAND)
			begin
				if (CMD_AUTO)
					auto_mem_q <= 1'b1;
				else if (CMD_NON_AUTO)
					auto_mem_q <= 1'b0;
			end
			else if (remote_f && sel != ARCMD_SEL_OPTO)
			begin
				if (sel == ARCMD_SEL_PULSE && auto_f_q && !auto_f)
					auto_mem_q <= !auto_mem_q;
				else if (CMD_AUTO)
					auto_mem_q <= 1'b1;
				else if (CMD_NON_AUTO)
					auto_mem_q <= 1'b0;
			end
			else if (!(remote_f_q && !remote_f))
				auto_mem_q <= auto_f;
		end
	end
	assign live_eff = live_f;
	assign auto_eff = auto_mem_q && !live_eff;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			AUTO_MODE <= 1'b0;
			LIVE_LINE_MODE <= 1'b0;
			NV_AUTO_MEM_OUT <= 1'b0;
		end
		else
		begin
			AUTO_MODE <= auto_eff;
			LIVE_LINE_MODE <= live_eff;
			NV_AUTO_MEM_OUT <= auto_mem_q;
		end
	end
	// Per-stage initiation choice, two bits per stage.
	always_comb
	begin
		main_trip = 1'b0;
		main_start = 1'b0;
		sef_trip = 1'b0;
		sef_start = 1'b0;
		block_req = 1'b0;
		noact_trip = 1'b0;
		for (int i = 0; i < `ARCMD_CH_NUM; i++)
		begin
			unique case (arcmd_init_e'(STAGE_CHOICE[2*i +: 2]))
				ARCMD_INIT_MAIN:
				begin
					main_trip = main_trip | STAGE_TRIP[i];
					main_start = main_start | STAGE_START[i];
				end
				ARCMD_INIT_SEF:
				begin
					sef_trip = sef_trip | STAGE_TRIP[i];
					sef_start = sef_start | STAGE_START[i];
				end
				ARCMD_INIT_BLOCK:
					block_req = block_req | STAGE_TRIP[i] | STAGE_START[i];
				ARCMD_INIT_NONE:
					noact_trip = noact_trip | STAGE_TRIP[i];
			endcase
		end
		if (arcmd_init_e'(EXT_CHOICE) == ARCMD_INIT_MAIN)
		begin
			main_trip = main_trip | EXTERNAL_TRIP_INITIATE;
			main_start = main_start | EXTERNAL_START_INITIATE;
		end
	end
	assign gate_ok = auto_eff && !live_eff && !MAIN_SHOTS_REACHED && !SEF_SHOTS_REACHED
		&& !CB_LOCKOUT && IN_SERVICE && !block_req;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			RECLOSE_INITIATE <= 1'b0;
			SENSITIVE_RECLOSE_INITIATE <= 1'b0;
			RECLOSE_BLOCKED <= 1'b0;
			TRIP_NO_RECLOSE <= 1'b0;
		end
		else
		begin
			RECLOSE_INITIATE <= gate_ok && (main_trip || (main_start && SEQ_COORD_EN));
			SENSITIVE_RECLOSE_INITIATE <= gate_ok
				&& (sef_trip || (sef_start && SEQ_COORD_EN));
			RECLOSE_BLOCKED <= block_req;
			TRIP_NO_RECLOSE <= noact_trip && !main_trip && !sef_trip;
		end
	end
	// Instantaneous blocking; trip numbers outside 1..5 never select a per-trip bit.
	assign trip_idx = TRIP_NUMBER - 3'h1;
	assign inst_cond = (PENULTIMATE_COUNT && PENULTIMATE_COUNT_BLOCK_SETTING)
		|| (CB_LOCKOUT && LOCKOUT_BLOCK_SETTING)
		|| (MANUAL_CLOSE_ACTIVE && MANUAL_CLOSE_BLOCK_SETTING)
		|| (!auto_eff && !live_eff && NON_AUTO_BLOCK_SETTING);
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			MAIN_PROTECTION_BLOCK_OUT <= 1'b0;
			SENSITIVE_PROTECTION_BLOCK_OUT <= 1'b0;
		end
		else
		begin
			MAIN_PROTECTION_BLOCK_OUT <= inst_cond || (TRIP_NUMBER >= 3'h1
				&& TRIP_NUMBER <= 3'h5 && PER_TRIP_MAIN_INST_BLOCK[trip_idx]);
			SENSITIVE_PROTECTION_BLOCK_OUT <= inst_cond || (TRIP_NUMBER >= 3'h1
				&& TRIP_NUMBER <= 3'h5 && PER_TRIP_SENSITIVE_INST_BLOCK[trip_idx]);
		end
	end
	// Dead time. A rising protection trip or start ends the primed state.
	assign prot_op = |(STAGE_TRIP | STAGE_START) || EXTERNAL_TRIP_INITIATE
		|| EXTERNAL_START_INITIATE;
	assign dt_run = (dt_q == ARCMD_DT_PRIMED) && dte_s;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			dt_q <= ARCMD_DT_IDLE;
			dt_cnt_q <= 16'h0000;
			any_prot_q <= 1'b0;
		end
		else
		begin
			any_prot_q <= prot_op;
			unique case (dt_q)
				ARCMD_DT_IDLE:
				begin
					dt_cnt_q <= 16'h0000;
					if (cb_open_s && permit_s && !SCHEME_RESET
						&& !(START_ON_PROT_RESET && prot_op))
						dt_q <= ARCMD_DT_PRIMED;
				end
				ARCMD_DT_PRIMED:
				begin
					if (SCHEME_RESET || (prot_op && !any_prot_q))
						dt_q <= ARCMD_DT_IDLE;
					else if (dt_run && tick)
					begin
						if (dt_cnt_q + 16'h0001 >= DEAD_TIME_TICKS)
							dt_q <= ARCMD_DT_DONE;
						dt_cnt_q <= dt_cnt_q + 16'h0001;
					end
				end
				ARCMD_DT_DONE:
				begin
					if (SCHEME_RESET || (prot_op && !any_prot_q))
						dt_q <= ARCMD_DT_IDLE;
				end
				default:
					dt_q <= ARCMD_DT_IDLE;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			RECLOSE_CHECKS <= 1'b0;
			DEAD_TIME_IN_PROGRESS <= 1'b0;
			DEAD_TIME_COMPLETE <= 1'b0;
			CLOSE_PERMIT <= 1'b0;
		end
		else
		begin
			RECLOSE_CHECKS <= dt_q == ARCMD_DT_PRIMED;
			DEAD_TIME_IN_PROGRESS <= dt_run;
			DEAD_TIME_COMPLETE <= dt_q == ARCMD_DT_DONE;
			CLOSE_PERMIT <= (dt_q == ARCMD_DT_DONE) || (dt_run
				&& IMMEDIATE_SYNCHRONISED_RECLOSE && BOTH_LIVE_IN_SYNC);
		end
	end
endmodule : arcmd_top

// file: test/arcmd_switch.sv
`timescale 1ns/1ns
module arcmd_switch
(
	input wire logic [1:0] pos,
	output logic auto_o,
	output logic remote_o,
	output logic live_o
);
	// Positions: 0 non-auto, 1 remote, 2 auto, 3 live line.
	// A move goes straight to the new position; no break-before-make pass through non-auto is modelled.
	assign auto_o = (pos == 2'h2);
	assign remote_o = (pos == 2'h1);
	assign live_o = (pos == 2'h3);
endmodule : arcmd_switch

// file: test/arcmd_top_properties.sv
`timescale 1ns/1ns
module arcmd_checker
	import arcmd_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic [15:0] STAGE_START,
	input wire logic [15:0] STAGE_TRIP,
	input wire logic [1:0] EXT_CHOICE,
	input wire logic MAIN_SHOTS_REACHED,
	input wire logic SEF_SHOTS_REACHED,
	input wire logic CB_LOCKOUT,
	input wire logic IN_SERVICE,
	input wire logic [2:0] TRIP_NUMBER,
	input wire logic [4:0] PER_TRIP_MAIN_INST_BLOCK,
	input wire logic PENULTIMATE_COUNT,
	input wire logic PENULTIMATE_COUNT_BLOCK_SETTING,
	input wire logic LOCKOUT_BLOCK_SETTING,
	input wire logic CB_OPEN,
	input wire logic DEAD_TIME_START_PERMISSION,
	input wire logic AUTO_MODE,
	input wire logic LIVE_LINE_MODE,
	input wire logic RECLOSE_INITIATE,
	input wire logic RECLOSE_BLOCKED,
	input wire logic MAIN_PROTECTION_BLOCK_OUT,
	input wire logic RECLOSE_CHECKS,
	input wire logic DEAD_TIME_IN_PROGRESS
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	a_live_no_auto: assert property (LIVE_LINE_MODE |-> !AUTO_MODE)
		else $error("auto mode with live line");
	a_init_gated: assert property (RECLOSE_INITIATE |-> $past(IN_SERVICE && !CB_LOCKOUT
		&& !MAIN_SHOTS_REACHED && !SEF_SHOTS_REACHED)) else $error("initiate with gate shut");
	a_block_veto: assert property (RECLOSE_BLOCKED |-> !RECLOSE_INITIATE)
		else $error("initiate while blocked");
	a_ext_choice: assert property ($past(EXT_CHOICE != ARCMD_INIT_MAIN && STAGE_TRIP == 16'h0
		&& STAGE_START == 16'h0) |-> !RECLOSE_INITIATE) else $error("external initiate honoured");
	a_per_trip: assert property ($past(TRIP_NUMBER == 3'h2 && PER_TRIP_MAIN_INST_BLOCK[1])
		|-> MAIN_PROTECTION_BLOCK_OUT) else $error("trip two not blocked");
	a_penult_block: assert property ($past(PENULTIMATE_COUNT
		&& PENULTIMATE_COUNT_BLOCK_SETTING) |-> MAIN_PROTECTION_BLOCK_OUT) else $error("penult");
	a_lockout_block: assert property ($past(CB_LOCKOUT && LOCKOUT_BLOCK_SETTING)
		|-> MAIN_PROTECTION_BLOCK_OUT) else $error("lockout not blocking");
	a_checks_cause: assert property ($rose(RECLOSE_CHECKS) |-> $past(CB_OPEN, 4)
		&& $past(DEAD_TIME_START_PERMISSION, 4)) else $error("primed without cause");
	a_prog_checks: assert property (DEAD_TIME_IN_PROGRESS |-> RECLOSE_CHECKS)
		else $error("dead time runs unprimed");
	c_init: cover property (RECLOSE_INITIATE);
	c_prog: cover property (DEAD_TIME_IN_PROGRESS);
	c_live: cover property (LIVE_LINE_MODE);
endmodule : arcmd_checker
bind arcmd_top arcmd_checker arcmd_checker_i (.*);

// file: test/test_arcmd_top.sv
`timescale 1ns/1ns
`include "arcmd_params.svh"
`define CHK(n, e, g) \
	begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_arcmd_top
	import arcmd_pkg::*;
;
	int bad_count = 0;
	int n_tests = 0;
	logic CORE_CLK = 1'h0, ARST_N = 1'h0, CMD_AUTO = 1'h0, CMD_NON_AUTO = 1'h0;
	logic NV_AUTO_MEM = 1'h1, NV_VALID = 1'h1, EXTERNAL_TRIP_INITIATE = 1'h0;
	logic EXTERNAL_START_INITIATE = 1'h0, SEQ_COORD_EN = 1'h1, MAIN_SHOTS_REACHED = 1'h0;
	logic SEF_SHOTS_REACHED = 1'h0, CB_LOCKOUT = 1'h0, IN_SERVICE = 1'h1, CB_OPEN = 1'h0;
	logic PENULTIMATE_COUNT = 1'h0, PENULTIMATE_COUNT_BLOCK_SETTING = 1'h0;
	logic LOCKOUT_BLOCK_SETTING = 1'h0, MANUAL_CLOSE_ACTIVE = 1'h0, SCHEME_RESET = 1'h0;
	logic MANUAL_CLOSE_BLOCK_SETTING = 1'h0, NON_AUTO_BLOCK_SETTING = 1'h1;
	logic START_ON_PROT_RESET = 1'h0, DEAD_TIME_START_PERMISSION = 1'h0;
	logic DEAD_TIME_ENABLE = 1'h0, DEAD_TIME_ENABLE_MAPPED = 1'h1, BOTH_LIVE_IN_SYNC = 1'h0;
	logic IMMEDIATE_SYNCHRONISED_RECLOSE = 1'h0;
	logic [1:0] MODE_SELECT = 2'h0, EXT_CHOICE = 2'h0, sw_pos = 2'h0;
	logic [15:0] STAGE_START = 16'h0, STAGE_TRIP = 16'h0, STAGE_CHOICE = 16'h0;
	logic [15:0] DEAD_TIME_TICKS = 16'h0064;
	logic [2:0] TRIP_NUMBER = 3'h0;
	logic [4:0] PER_TRIP_MAIN_INST_BLOCK = 5'h0, PER_TRIP_SENSITIVE_INST_BLOCK = 5'h0;
	logic AUTO_IN, REMOTE_SEL_IN, LIVE_LINE_IN, AUTO_MODE, LIVE_LINE_MODE, NV_AUTO_MEM_OUT;
	logic RECLOSE_INITIATE, SENSITIVE_RECLOSE_INITIATE, RECLOSE_BLOCKED, TRIP_NO_RECLOSE;
	logic MAIN_PROTECTION_BLOCK_OUT, SENSITIVE_PROTECTION_BLOCK_OUT, RECLOSE_CHECKS;
	logic DEAD_TIME_IN_PROGRESS, DEAD_TIME_COMPLETE, CLOSE_PERMIT;
	arcmd_top arcmd_top_i (.*);
	arcmd_switch arcmd_switch_i (.pos(sw_pos), .auto_o(AUTO_IN), .remote_o(REMOTE_SEL_IN),
		.live_o(LIVE_LINE_IN));
	always #10 CORE_CLK = ~CORE_CLK;
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask : cyc
	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic t_mode;
		cyc(3);
		`CHK("auto", 1'h1, AUTO_MODE)
		`CHK("nv", 1'h1, NV_AUTO_MEM_OUT)
		@(posedge CORE_CLK);
		CMD_NON_AUTO <= 1'h1;
		cyc(4);
		`CHK("auto", 1'h0, AUTO_MODE)
		`CHK("mblk", 1'h1, MAIN_PROTECTION_BLOCK_OUT)
		CMD_NON_AUTO <= 1'h0;
		CMD_AUTO <= 1'h1;
		cyc(4);
		`CHK("auto", 1'h1, AUTO_MODE)
	endtask : t_mode
	task automatic t_init;
		for (int c = 0; c < 4; c++)
		begin
			@(posedge CORE_CLK);
			STAGE_CHOICE <= 16'(c);
			STAGE_TRIP <= 16'h0001;
			cyc(3);
			`CHK("init", c == 1, RECLOSE_INITIATE)
			`CHK("sef", c == 2, SENSITIVE_RECLOSE_INITIATE)
			`CHK("blk", c == 3, RECLOSE_BLOCKED)
			`CHK("noact", c == 0, TRIP_NO_RECLOSE)
			STAGE_TRIP <= 16'h0000;
			cyc(3);
		end
		// Pass four turns co-ordination off, which stops a start but not a trip.
		for (int k = 0; k < 6; k++)
		begin
			@(posedge CORE_CLK);
			{SEQ_COORD_EN, CB_LOCKOUT, MAIN_SHOTS_REACHED, SEF_SHOTS_REACHED, IN_SERVICE} <=
				5'h11 ^ (5'h1 << k);
			STAGE_CHOICE <= 16'h0001;
			STAGE_START <= 16'h0001;
			cyc(3);
			`CHK("gate", k == 5, RECLOSE_INITIATE)
			STAGE_START <= 16'h0000;
			STAGE_TRIP <= 16'h0001;
			cyc(3);
			`CHK("gtrip", k > 3, RECLOSE_INITIATE)
			STAGE_TRIP <= 16'h0000;
			cyc(3);
		end
		for (int e = 0; e < 4; e++)
		begin
			@(posedge CORE_CLK);
			{SEQ_COORD_EN, EXT_CHOICE, EXTERNAL_TRIP_INITIATE} <= {1'h1, 2'(e), 1'h1};
			cyc(3);
			`CHK("ext", e == 1, RECLOSE_INITIATE)
			EXTERNAL_TRIP_INITIATE <= 1'h0;
			cyc(3);
		end
	endtask : t_init
	task automatic t_inst;
		for (int n = 1; n < 6; n++)
		begin
			@(posedge CORE_CLK);
			TRIP_NUMBER <= 3'(n);
			PER_TRIP_MAIN_INST_BLOCK <= 5'h1 << (n - 1);
			PER_TRIP_SENSITIVE_INST_BLOCK <= ~(5'h1 << (n - 1));
			cyc(3);
			`CHK("mblk", 1'h1, MAIN_PROTECTION_BLOCK_OUT)
			`CHK("sblk", 1'h0, SENSITIVE_PROTECTION_BLOCK_OUT)
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge CORE_CLK);
			{PER_TRIP_MAIN_INST_BLOCK, PER_TRIP_SENSITIVE_INST_BLOCK} <= 10'h0;
			{PENULTIMATE_COUNT, CB_LOCKOUT, MANUAL_CLOSE_ACTIVE} <= 3'h1 << i;
			{PENULTIMATE_COUNT_BLOCK_SETTING, LOCKOUT_BLOCK_SETTING,
				MANUAL_CLOSE_BLOCK_SETTING} <= 3'h7;
			cyc(3);
			`CHK("cblk", i < 3, MAIN_PROTECTION_BLOCK_OUT)
		end
	endtask : t_inst
	task automatic t_dead;
		@(posedge CORE_CLK);
		CB_OPEN <= 1'h1;
		cyc(6);
		`CHK("prime", 1'h0, RECLOSE_CHECKS)
		DEAD_TIME_START_PERMISSION <= 1'h1;
		cyc(6);
		`CHK("prime", 1'h1, RECLOSE_CHECKS)
		`CHK("run", 1'h0, DEAD_TIME_IN_PROGRESS)
		DEAD_TIME_ENABLE <= 1'h1;
		cyc(6);
		`CHK("run", 1'h1, DEAD_TIME_IN_PROGRESS)
		{DEAD_TIME_ENABLE, DEAD_TIME_ENABLE_MAPPED, IMMEDIATE_SYNCHRONISED_RECLOSE} <= 3'h1;
		cyc(6);
		`CHK("run", 1'h1, DEAD_TIME_IN_PROGRESS)
		`CHK("perm", 1'h0, CLOSE_PERMIT)
		BOTH_LIVE_IN_SYNC <= 1'h1;
		cyc(3);
		`CHK("perm", 1'h1, CLOSE_PERMIT)
		STAGE_TRIP <= 16'h0001;
		START_ON_PROT_RESET <= 1'h1;
		cyc(3);
		`CHK("prime", 1'h0, RECLOSE_CHECKS)
		{STAGE_TRIP, BOTH_LIVE_IN_SYNC, DEAD_TIME_TICKS} <= {16'h0000, 1'h0, 16'h0001};
		cyc(3);
		`CHK("prime", 1'h1, RECLOSE_CHECKS)
		`CHK("perm", 1'h0, CLOSE_PERMIT)
		`CHK("done", 1'h0, DEAD_TIME_COMPLETE)
		// The first tick after re-priming ends a one-tick dead time.
		for (int w = 0; w < `ARCMD_TICK_CYC + 4 && !DEAD_TIME_COMPLETE; w++)
			cyc(1);
		`CHK("done", 1'h1, DEAD_TIME_COMPLETE)
		`CHK("perm", 1'h1, CLOSE_PERMIT)
		{STAGE_TRIP, CB_OPEN, SCHEME_RESET} <= 18'h1;
		cyc(6);
		`CHK("done", 1'h0, DEAD_TIME_COMPLETE)
		SCHEME_RESET <= 1'h0;
	endtask : t_dead
	task automatic t_live;
		@(posedge CORE_CLK);
		{MODE_SELECT, sw_pos, STAGE_CHOICE} <= {2'h1, 2'h2, 16'h0001};
		cyc(6);
		`CHK("auto", 1'h1, AUTO_MODE)
		sw_pos <= 2'h0;
		cyc(1000);
		`CHK("auto", 1'h1, AUTO_MODE)
		{MODE_SELECT, sw_pos, CMD_AUTO} <= {2'h2, 2'h1, 1'h0};
		cyc(6);
		`CHK("auto", 1'h1, AUTO_MODE)
		CMD_NON_AUTO <= 1'h1;
		cyc(4);
		`CHK("auto", 1'h0, AUTO_MODE)
		CMD_NON_AUTO <= 1'h0;
		cyc(3);
		`CHK("auto", 1'h0, AUTO_MODE)
		CMD_AUTO <= 1'h1;
		cyc(4);
		`CHK("auto", 1'h1, AUTO_MODE)
		sw_pos <= 2'h3;
		STAGE_TRIP <= 16'h0001;
		cyc(6);
		`CHK("live", 1'h1, LIVE_LINE_MODE)
		`CHK("auto", 1'h0, AUTO_MODE)
		`CHK("init", 1'h0, RECLOSE_INITIATE)
	endtask : t_live
	initial
	begin
		#1400000;
		bad_count++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge CORE_CLK);
		ARST_N <= 1'h1;
		t_mode();
		t_init();
		t_inst();
		t_dead();
		t_live();
		test_done();
	end
endmodule : test_arcmd_top
